/* rtl/dcf_pkg.sv */
// dcf_pkg: shared constants and state types of the dma crc and channel flag block
package dcf_pkg;
  //--------------------------------------------------------------
  // sizes
  //--------------------------------------------------------------
  localparam int NCH   = 8;
  localparam int CH_W  = 3;
  localparam int ADR_W = 8;
  localparam int FLG_W = 5;

  //--------------------------------------------------------------
  // register byte addresses
  //--------------------------------------------------------------
  localparam logic [7:0] ADR_CRC_CTRL = 8'h00;
  localparam logic [7:0] ADR_CRC_RES  = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] ADR_IRQ_EN   = 8'h10;
  localparam logic [7:0] ADR_CH_EVT   = 8'h20;
  localparam logic [7:0] ADR_CH_CFG   = 8'h40;
  localparam logic [2:0] EVT_PAGE     = ADR_CH_EVT[7:5];
  localparam logic [2:0] CFG_PAGE     = ADR_CH_CFG[7:5];

  //--------------------------------------------------------------
  // field positions
  //--------------------------------------------------------------
  localparam int CTL_CH_LSB   = 0;
  localparam int CTL_TYP_BIT  = 5;
  localparam int CTL_APP_BIT  = 6;
  localparam int CTL_WBO_BIT  = 8;
  localparam int FLG_ADDR     = 0;
  localparam int FLG_ABORT    = 1;
  localparam int FLG_CELL     = 2;
  localparam int FLG_BLOCK    = 3;
  localparam int FLG_HALF     = 4;
  localparam int CFG_SSZ_LSB  = 0;
  localparam int CFG_DSZ_LSB  = 8;
  localparam int CFG_CSZ_LSB  = 16;
  localparam int CFG_AIRQ_LSB = 24;

  //--------------------------------------------------------------
  // data path constants
  //--------------------------------------------------------------
  localparam logic [8:0]  BEAT_BYTES = 9'h004;
  localparam logic [31:0] CRC_POLY   = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED   = 32'hFFFFFFFF;
  localparam logic [31:0] IP_EMPTY   = 32'h0000FFFF;

  //--------------------------------------------------------------
  // state types and reset values
  //--------------------------------------------------------------
  typedef struct packed {
    logic                 ack;
    logic [31:0]          rdat;
    logic                 irq;
    logic                 write_byte_order_enable;
    logic                 app;
    logic                 typ;
    logic [CH_W-1:0]      sel_ch;
    logic [NCH-1:0]       irq_en;
    logic [NCH-1:0][31:0] cfg;
    logic                 crc_pend;
    logic [31:0]          crc_last;
    logic                 dv;
    logic [CH_W-1:0]      dch;
    logic [31:0]          ddat;
    logic                 dcrc;
  } dcf_top_s;

  typedef struct packed {
    logic [8:0]       cnt;
    logic [8:0]       dptr;
    logic [8:0]       ccnt;
    logic [FLG_W-1:0] flg;
  } dcf_chan_s;

  typedef struct packed {
    logic [31:0] acc;
  } dcf_crc_s;

  localparam dcf_top_s  TOP_RST  = '0;
  localparam dcf_chan_s CHAN_RST = '0;
  localparam dcf_crc_s  CRC_RST  = '{acc: CRC_SEED};
endpackage : dcf_pkg

/* rtl/dcf_crc.sv */
// dcf_crc: lfsr crc-32 and ip header checksum engine, one word per cycle
`timescale 1ns/1ps
module dcf_crc (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ip_mode,
  input  wire logic        clr,
  input  wire logic        din_valid,
  input  wire logic [31:0] din,
  output logic      [31:0] res
);
  import dcf_pkg::*;

  dcf_crc_s st_ff;
  dcf_crc_s nxt_st;
  logic [31:0] seed;

  // msb-first lfsr over one word
  function automatic logic [31:0] lfsr_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction : lfsr_step

  // ones complement sum of both halfwords, carries folded back
  function automatic logic [15:0] ones_add(input logic [15:0] c, input logic [31:0] d);
    logic [17:0] s;
    s = {2'b00, c} + {2'b00, d[31:16]} + {2'b00, d[15:0]};
    s = {16'h0000, s[17:16]} + {2'b00, s[15:0]};
    s = {16'h0000, s[17:16]} + {2'b00, s[15:0]};
    return s[15:0];
  endfunction : ones_add

  // clear restarts from the seed, a word in the same cycle counts
  always_comb begin
    seed   = ip_mode ? 32'h00000000 : CRC_SEED;
    nxt_st = st_ff;
    if (clr) nxt_st.acc = seed;
    if (din_valid) begin
      if (ip_mode) nxt_st.acc = {16'h0000, ones_add(nxt_st.acc[15:0], din)};
      else nxt_st.acc = lfsr_step(nxt_st.acc, din);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) st_ff <= CRC_RST;
    else st_ff <= nxt_st;
  end

  assign res = ip_mode ? {16'h0000, ~st_ff.acc[15:0]} : st_ff.acc;

  default clocking crc_cb @(posedge clk); endclocking
  default disable iff (rst);

  a_type_empty_value: assert property (
    (clr && !din_valid) |=> (res == (ip_mode ? IP_EMPTY : CRC_SEED)))
    else $error("engine seed does not match selected type");

  a_ip_sum_vector: assert property (
    (ip_mode && clr && din_valid && din == 32'h00010002) ##1 ip_mode |-> res == 32'h0000FFFC)
    else $error("ip checksum wrong for known word");
endmodule : dcf_crc

/* rtl/dcf_chan.sv */
// dcf_chan: per-channel byte counters and sticky event flags
`timescale 1ns/1ps
module dcf_chan (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      beat,
  input  wire logic                      dst_wr,
  input  wire logic                      pat,
  input  wire logic                      bad,
  input  wire logic                      irq_valid,
  input  wire logic [7:0]                irq_num,
  input  wire logic [31:0]               cfg,
  input  wire logic                      evt_we,
  input  wire logic [dcf_pkg::FLG_W-1:0] evt_wdata,
  input  wire logic                      clr_all,
  output logic      [dcf_pkg::FLG_W-1:0] flags,
  output logic                           blk_end
);
  import dcf_pkg::*;

  dcf_chan_s        st_ff;
  dcf_chan_s        nxt_st;
  logic [FLG_W-1:0] ev;
  logic [8:0]       ssz;
  logic [8:0]       dsz;
  logic [8:0]       csz;
  logic [8:0]       big;
  logic [8:0]       half;
  logic             abort_hit;

  // a size field of zero means 256 bytes
  assign ssz       = {cfg[CFG_SSZ_LSB +: 8] == 8'h00, cfg[CFG_SSZ_LSB +: 8]};
  assign dsz       = {cfg[CFG_DSZ_LSB +: 8] == 8'h00, cfg[CFG_DSZ_LSB +: 8]};
  assign csz       = {cfg[CFG_CSZ_LSB +: 8] == 8'h00, cfg[CFG_CSZ_LSB +: 8]};
  assign big       = (ssz > dsz) ? ssz : dsz;
  assign half      = {1'b0, dsz[8:1]};
  assign abort_hit = irq_valid & (irq_num == cfg[CFG_AIRQ_LSB +: 8]);
  assign flags     = st_ff.flg;

  // counters advance per beat, events then merge into the flags
  always_comb begin
    nxt_st  = st_ff;
    ev      = '0;
    blk_end = 1'b0;
    if (abort_hit) begin
      ev[FLG_ABORT] = 1'b1;
      nxt_st.cnt    = '0;
      nxt_st.dptr   = '0;
      nxt_st.ccnt   = '0;
    end else if (beat) begin
      nxt_st.cnt  = st_ff.cnt + BEAT_BYTES;
      nxt_st.ccnt = st_ff.ccnt + BEAT_BYTES;
      if (dst_wr) nxt_st.dptr = st_ff.dptr + BEAT_BYTES;
      if (dst_wr && nxt_st.dptr == half) ev[FLG_HALF] = 1'b1;
      if (nxt_st.ccnt == csz) begin
        ev[FLG_CELL] = 1'b1;
        nxt_st.ccnt  = '0;
      end
      if (nxt_st.cnt >= big || pat) begin
        ev[FLG_BLOCK] = 1'b1;
        blk_end       = 1'b1;
        nxt_st.cnt    = '0;
        nxt_st.dptr   = '0;
        nxt_st.ccnt   = '0;
      end
    end
    if (bad) ev[FLG_ADDR] = 1'b1;
    // software writes only clear; an event in the same cycle wins
    if (clr_all) nxt_st.flg = '0;
    else if (evt_we) nxt_st.flg = st_ff.flg & evt_wdata;
    nxt_st.flg = nxt_st.flg | ev;
  end

  always_ff @(posedge clk) begin
    if (rst) st_ff <= CHAN_RST;
    else st_ff <= nxt_st;
  end

  default clocking ch_cb @(posedge clk); endclocking
  default disable iff (rst);

  a_half_flag_set: assert property (
    (beat && dst_wr && !abort_hit && st_ff.dptr + BEAT_BYTES == half) |=> flags[FLG_HALF])
    else $error("half flag missed at midpoint");

  a_block_done_set: assert property (
    (beat && !abort_hit && (st_ff.cnt + BEAT_BYTES >= big || pat))
    |=> (flags[FLG_BLOCK] && st_ff.cnt == 9'h000))
    else $error("block flag or counter restart missed");

  a_cell_done_set: assert property (
    (beat && !abort_hit && st_ff.ccnt + BEAT_BYTES == csz) |=> flags[FLG_CELL])
    else $error("cell flag missed");

  a_abort_flag_set: assert property (
    abort_hit |=> (flags[FLG_ABORT] && st_ff.cnt == 9'h000))
    else $error("abort not taken");

  a_addr_err_set: assert property (
    bad |=> flags[FLG_ADDR])
    else $error("address error flag missed");

  a_flag_sticky: assert property (
    (flags[FLG_BLOCK] && !clr_all && !(evt_we && !evt_wdata[FLG_BLOCK])) |=> flags[FLG_BLOCK])
    else $error("block flag dropped without a clear");

  a_zero_write_clears: assert property (
    (evt_we && evt_wdata == '0 && !beat && !bad && !abort_hit) |=> flags == '0)
    else $error("writing zero did not clear flags");
endmodule : dcf_chan

/* rtl/dcf_top.sv */
// dcf_top: crc attachment controls, channel event flags and wishbone slave
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module dcf_top (
  input  wire logic                      CLK,
  input  wire logic                      RST,
  input  wire logic                      CYC_I,
  input  wire logic                      STB_I,
  input  wire logic                      WE_I,
  input  wire logic [dcf_pkg::ADR_W-1:0] ADR_I,
  input  wire logic [3:0]                SEL_I,
  input  wire logic [31:0]               DAT_I,
  output logic      [31:0]               DAT_O,
  output logic                           ACK_O,
  output logic                           IRQ,
  input  wire logic                      XFER_VALID,
  input  wire logic [dcf_pkg::CH_W-1:0]  XFER_CH,
  input  wire logic [31:0]               XFER_DATA,
  input  wire logic                      XFER_UNALIGNED,
  input  wire logic                      XFER_SRC_BAD,
  input  wire logic                      XFER_DST_BAD,
  input  wire logic                      XFER_PAT,
  input  wire logic                      IRQ_VALID,
  input  wire logic [7:0]                IRQ_NUM,
  output logic                           DST_VALID,
  output logic      [dcf_pkg::CH_W-1:0]  DST_CH,
  output logic      [31:0]               DST_DATA,
  output logic                           DST_CRC
);
  import dcf_pkg::*;

  //--------------------------------------------------------------
  // declarations
  //--------------------------------------------------------------
  dcf_top_s                  st_ff;
  dcf_top_s                  nxt_st;
  logic [NCH-1:0][FLG_W-1:0] flags;
  logic [NCH-1:0]            blk_end;
  logic [NCH-1:0]            beat;
  logic [NCH-1:0]            ch_dst;
  logic [NCH-1:0]            ch_bad;
  logic [NCH-1:0]            evt_we;
  logic [NCH-1:0]            clr_ch;
  logic [NCH-1:0]            any_flag;
  logic [31:0]               crc_res;
  logic [31:0]               wmask;
  logic [31:0]               swap;
  logic [ADR_W-1:0]          adr;
  logic                      acc;
  logic                      wr;
  logic                      bad;
  logic                      beat_any;
  logic                      crc_beat;
  logic                      dst_wr;

  //--------------------------------------------------------------
  // bus decode
  //--------------------------------------------------------------
  // one access per request; ack blocks a second take
  assign acc   = CYC_I & STB_I & ~st_ff.ack;
  assign wr    = acc & WE_I;
  assign adr   = {ADR_I[ADR_W-1:2], 2'b00};
  assign wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

  //--------------------------------------------------------------
  // beat qualification
  //--------------------------------------------------------------
  // bad addresses and unaligned beats under byte order are dropped
  assign bad = XFER_VALID & (XFER_SRC_BAD | XFER_DST_BAD
                             | (st_ff.write_byte_order_enable & XFER_UNALIGNED));
  // an aborted channel moves nothing until its flag is cleared
  assign beat_any = XFER_VALID & ~bad & ~flags[XFER_CH][FLG_ABORT];
  assign crc_beat = beat_any & (XFER_CH == st_ff.sel_ch);
  // append mode keeps the crc channel off the destination
  assign dst_wr   = beat_any & ~(st_ff.app & crc_beat);
  // byte order reversal for the destination write
  assign swap     = {XFER_DATA[7:0], XFER_DATA[15:8], XFER_DATA[23:16], XFER_DATA[31:24]};

  //--------------------------------------------------------------
  // channels
  //--------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign beat[c]     = beat_any & (XFER_CH == CH_W'(c));
    assign ch_dst[c]   = dst_wr & (XFER_CH == CH_W'(c));
    assign ch_bad[c]   = bad & (XFER_CH == CH_W'(c));
    assign evt_we[c]   = wr & SEL_I[0] & (adr == ADR_W'(ADR_CH_EVT + 4 * c));
    assign clr_ch[c]   = wr & SEL_I[0] & (adr == ADR_IRQ_CLR) & DAT_I[c];
    assign any_flag[c] = |flags[c];

    dcf_chan u_chan (
      .clk       (CLK),
      .rst       (RST),
      .beat      (beat[c]),
      .dst_wr    (ch_dst[c]),
      .pat       (XFER_PAT),
      .bad       (ch_bad[c]),
      .irq_valid (IRQ_VALID),
      .irq_num   (IRQ_NUM),
      .cfg       (st_ff.cfg[c]),
      .evt_we    (evt_we[c]),
      .evt_wdata (DAT_I[FLG_W-1:0]),
      .clr_all   (clr_ch[c]),
      .flags     (flags[c]),
      .blk_end   (blk_end[c])
    );
  end

  //--------------------------------------------------------------
  // crc engine
  //--------------------------------------------------------------
  // restarted the cycle after the attached channel ends a block
  dcf_crc u_crc (
    .clk       (CLK),
    .rst       (RST),
    .ip_mode   (st_ff.typ),
    .clr       (st_ff.crc_pend),
    .din_valid (crc_beat),
    .din       (XFER_DATA),
    .res       (crc_res)
  );

  //--------------------------------------------------------------
  // next state
  //--------------------------------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.ack  = acc;
    nxt_st.rdat = 32'h00000000;
    // read mux; unmapped words read zero
    if (acc && !WE_I) begin
      case (adr)
        ADR_CRC_CTRL: begin
          nxt_st.rdat[CTL_WBO_BIT]          = st_ff.write_byte_order_enable;
          nxt_st.rdat[CTL_APP_BIT]          = st_ff.app;
          nxt_st.rdat[CTL_TYP_BIT]          = st_ff.typ;
          nxt_st.rdat[CTL_CH_LSB +: CH_W]   = st_ff.sel_ch;
        end
        ADR_CRC_RES:  nxt_st.rdat          = st_ff.crc_last;
        ADR_IRQ_STAT: nxt_st.rdat[NCH-1:0] = any_flag;
        ADR_IRQ_EN:   nxt_st.rdat[NCH-1:0] = st_ff.irq_en;
        default: begin
          if (adr[7:5] == EVT_PAGE) nxt_st.rdat[FLG_W-1:0] = flags[adr[4:2]];
          else if (adr[7:5] == CFG_PAGE) nxt_st.rdat = st_ff.cfg[adr[4:2]];
        end
      endcase
    end
    // register writes, byte lanes honoured
    if (wr) begin
      if (adr == ADR_CRC_CTRL) begin
        if (SEL_I[1]) nxt_st.write_byte_order_enable = DAT_I[CTL_WBO_BIT];
        if (SEL_I[0]) begin
          nxt_st.app    = DAT_I[CTL_APP_BIT];
          nxt_st.typ    = DAT_I[CTL_TYP_BIT];
          nxt_st.sel_ch = DAT_I[CTL_CH_LSB +: CH_W];
        end
        if (nxt_st.write_byte_order_enable) nxt_st.app = 1'b0;
      end
      if (adr == ADR_IRQ_EN && SEL_I[0]) nxt_st.irq_en = DAT_I[NCH-1:0];
      if (adr[7:5] == CFG_PAGE) begin
        nxt_st.cfg[adr[4:2]] = (st_ff.cfg[adr[4:2]] & ~wmask) | (DAT_I & wmask);
      end
    end
    // crc result is final one cycle after the block ends
    nxt_st.crc_pend = blk_end[st_ff.sel_ch];
    if (st_ff.crc_pend) nxt_st.crc_last = crc_res;
    // destination port: appended crc wins, a pass-through beat in the same cycle is dropped
    nxt_st.dv   = 1'b0;
    nxt_st.dcrc = 1'b0;
    if (st_ff.crc_pend && st_ff.app) begin
      nxt_st.dv   = 1'b1;
      nxt_st.dch  = st_ff.sel_ch;
      nxt_st.ddat = crc_res;
      nxt_st.dcrc = 1'b1;
    end else if (dst_wr) begin
      nxt_st.dv   = 1'b1;
      nxt_st.dch  = XFER_CH;
      nxt_st.ddat = st_ff.write_byte_order_enable ? swap : XFER_DATA;
    end
    // level interrupt while an enabled channel has a flag up
    nxt_st.irq = |(any_flag & st_ff.irq_en);
  end

  //--------------------------------------------------------------
  // state register
  //--------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) st_ff <= TOP_RST;
    else st_ff <= nxt_st;
  end

  // outputs straight from the state register
  assign DAT_O     = st_ff.rdat;
  assign ACK_O     = st_ff.ack;
  assign IRQ       = st_ff.irq;
  assign DST_VALID = st_ff.dv;
  assign DST_CH    = st_ff.dch;
  assign DST_DATA  = st_ff.ddat;
  assign DST_CRC   = st_ff.dcrc;

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  default clocking top_cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_bus_ack_pulse: assert property (
    (CYC_I && STB_I && !ACK_O) |=> ACK_O ##1 !ACK_O)
    else $error("ack not a single cycle answer");

  a_append_no_write: assert property (
    (crc_beat && st_ff.app && !st_ff.crc_pend) |=> !DST_VALID)
    else $error("append mode wrote source data out");

  a_append_crc_out: assert property (
    (blk_end[st_ff.sel_ch] && st_ff.app && !wr)
    |-> ##2 (DST_VALID && DST_CRC && DST_DATA == st_ff.crc_last))
    else $error("crc not written after append block");

  a_pass_byte_order: assert property (
    (dst_wr && !(st_ff.crc_pend && st_ff.app))
    |=> (DST_VALID && !DST_CRC && DST_CH == $past(XFER_CH)
         && DST_DATA == ($past(st_ff.write_byte_order_enable) ? $past(swap) : $past(XFER_DATA))))
    else $error("pass-through write wrong");

  a_crc_other_chan: assert property (
    (XFER_VALID && XFER_CH != st_ff.sel_ch && !st_ff.crc_pend && !wr) |=> $stable(crc_res))
    else $error("crc fed by an unattached channel");

  a_ctrl_resv_zero: assert property (
    (acc && !WE_I && adr == ADR_CRC_CTRL) |=> (ACK_O && DAT_O[4:3] == 2'b00))
    else $error("reserved control bits not zero");

  a_wbo_blocks_app: assert property (
    !(st_ff.write_byte_order_enable && st_ff.app))
    else $error("append set with byte order on");

  a_wbo_unaligned: assert property (
    (XFER_VALID && XFER_UNALIGNED && st_ff.write_byte_order_enable && !st_ff.crc_pend) |=> !DST_VALID)
    else $error("unaligned beat passed under byte order");

  a_abort_drops: assert property (
    (XFER_VALID && flags[XFER_CH][FLG_ABORT] && !st_ff.crc_pend) |=> !DST_VALID)
    else $error("aborted channel still writing");

  a_irq_level: assert property (
    (|(any_flag & st_ff.irq_en)) |=> IRQ)
    else $error("interrupt not raised");
endmodule : dcf_top

/* bench/dcf_src_model.sv */
// dcf_src_model: beat source standing in for the channel data path
`timescale 1ns/1ps
module dcf_src_model (
  input  wire logic clk,
  output logic        valid,
  output logic [2:0]  ch,
  output logic [31:0] data,
  output logic        unal,
  output logic        src_bad,
  output logic        dst_bad,
  output logic        pat
);
  initial begin
    {valid, ch, unal, src_bad, dst_bad, pat} = '0;
    data = 32'h5A5A5A5A;
  end
  // n back-to-back beats of d, d+1..; k = {pattern, unaligned, dest bad, source bad}
  task automatic burst(input logic [2:0] c, input int n, input logic [31:0] d,
                       input logic [3:0] k);
    int i;
    @(posedge clk);
    valid <= 1'b1;
    ch <= c;
    data <= d;
    {pat, unal, dst_bad, src_bad} <= k;
    for (i = 1; i < n; i++) begin
      @(posedge clk);
      data <= d + i;
    end
    @(posedge clk);
    valid <= 1'b0;
    data <= ~data; // released data never keeps the last word
    {pat, unal, dst_bad, src_bad} <= 4'h0;
  endtask : burst
endmodule : dcf_src_model

/* bench/dcf_top_tb_top.sv */
// dcf_top_tb_top: self-checking bench of the crc controls and channel flags
`timescale 1ns/1ps
module dcf_top_tb_top;
  logic CLK = 0, RST = 1, CYC_I = 0, STB_I = 0, WE_I = 0, IRQ_VALID = 0;
  logic [7:0] ADR_I = 8'h00, IRQ_NUM = 8'h00;
  logic [3:0] SEL_I = 4'hF;
  logic [31:0] DAT_I = 32'h0, DAT_O, DST_DATA, rd;
  logic ACK_O, IRQ, DST_VALID, DST_CRC, xv, xu, xs, xd, xp;
  logic [2:0] DST_CH, xc;
  logic [31:0] xdat;
  logic [35:0] dq[$];
  int fails = 0, samples_checked = 0;
  always #12.5 CLK = ~CLK;
  dcf_top dut (.CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ(IRQ),
    .XFER_VALID(xv), .XFER_CH(xc), .XFER_DATA(xdat), .XFER_UNALIGNED(xu),
    .XFER_SRC_BAD(xs), .XFER_DST_BAD(xd), .XFER_PAT(xp), .IRQ_VALID(IRQ_VALID),
    .IRQ_NUM(IRQ_NUM), .DST_VALID(DST_VALID), .DST_CH(DST_CH), .DST_DATA(DST_DATA),
    .DST_CRC(DST_CRC));
  dcf_src_model src (.clk(CLK), .valid(xv), .ch(xc), .data(xdat), .unal(xu),
    .src_bad(xs), .dst_bad(xd), .pat(xp));
  // destination writes seen at the port: {crc, channel, data}
  always @(posedge CLK) if (DST_VALID === 1'b1) dq.push_back({DST_CRC, DST_CH, DST_DATA});
  task automatic stop_test;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask : idle
  // classic single wishbone cycle, waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'b11, we, a, d};
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    rd = DAT_O;
    {CYC_I, STB_I, WE_I} <= 3'b000;
    if (ACK_O !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask : wb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk({4'h0, rd}, {4'h0, exp}, "register read");
  endtask : rchk
  task automatic t_ctrl;
    wb(1'b1, 8'h00, 32'h00000045);
    rchk(8'h00, 32'h00000045);
    wb(1'b1, 8'h00, 32'h000001FF);
    rchk(8'h00, 32'h00000127);
  endtask : t_ctrl
  task automatic t_pass;
    wb(1'b1, 8'h00, 32'h00000000);
    wb(1'b1, 8'h40, 32'h10040808);
    dq.delete();
    src.burst(3'd0, 2, 32'hA5A50000, 4'h0);
    idle(2);
    chk(dq.size(), 2, "write count");
    chk(dq[0], {4'h0, 32'hA5A50000}, "first write");
    chk(dq[1], {4'h0, 32'hA5A50001}, "second write");
    rchk(8'h20, 32'h0000001C);
    wb(1'b1, 8'h20, 32'h00000017);
    rchk(8'h20, 32'h00000014);
    wb(1'b1, 8'h20, 32'h00000000);
    rchk(8'h20, 32'h00000000);
  endtask : t_pass
  task automatic t_abort;
    @(posedge CLK);
    {IRQ_VALID, IRQ_NUM} <= {1'b1, 8'h10};
    @(posedge CLK);
    IRQ_VALID <= 1'b0;
    rchk(8'h20, 32'h00000002);
    dq.delete();
    src.burst(3'd0, 1, 32'h12345678, 4'h0);
    idle(2);
    chk(dq.size(), 0, "write after abort");
    wb(1'b1, 8'h10, 32'h00000001);
    idle(1);
    chk(IRQ, 1'b1, "irq enabled");
    rchk(8'h08, 32'h00000001);
    wb(1'b1, 8'h10, 32'h00000000);
    idle(1);
    chk(IRQ, 1'b0, "irq masked");
    wb(1'b1, 8'h0C, 32'h00000001);
    rchk(8'h08, 32'h00000000);
  endtask : t_abort
  task automatic t_err;
    dq.delete();
    src.burst(3'd1, 1, 32'h0000AAAA, 4'h1);
    src.burst(3'd1, 1, 32'h0000BBBB, 4'h2);
    idle(2);
    chk(dq.size(), 0, "bad address write");
    rchk(8'h24, 32'h00000001);
    wb(1'b1, 8'h44, 32'h00004040);
    src.burst(3'd4, 1, 32'h0000CCCC, 4'h8);
    rchk(8'h30, 32'h00000008);
  endtask : t_err
  task automatic t_wbo;
    wb(1'b1, 8'h00, 32'h00000103);
    wb(1'b1, 8'h4C, 32'h00004040);
    dq.delete();
    src.burst(3'd3, 1, 32'h11223344, 4'h0);
    idle(2);
    chk(dq[0], {1'b0, 3'd3, 32'h44332211}, "swapped write");
    src.burst(3'd3, 1, 32'h11223344, 4'h4);
    rchk(8'h2C, 32'h00000001);
  endtask : t_wbo
  task automatic t_app;
    wb(1'b1, 8'h00, 32'h00000062);
    wb(1'b1, 8'h48, 32'h00000404);
    dq.delete();
    // first beat ends a block and restarts the engine, the second opens the new sum
    src.burst(3'd2, 2, 32'h00010001, 4'h0);
    idle(3);
    chk(dq.size(), 2, "append write count");
    chk(dq[0][35:32], 4'hA, "first crc write");
    chk(dq[1], {1'b1, 3'd2, 32'h0000FFFC}, "crc write");
    rchk(8'h04, 32'h0000FFFC);
  endtask : t_app
  initial begin
    idle(5);
    RST <= 1'b0;
    idle(1);
    t_ctrl();
    t_pass();
    t_abort();
    t_err();
    t_wbo();
    t_app();
    stop_test();
  end
endmodule : dcf_top_tb_top
